/* File: rtl/can_node_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
module can_node_ctrl
(
  input  wire logic                     mclk,
  input  wire logic                     rst_n,
  input  wire logic [6:0]               nodeAddressSetting,
  input  wire logic                     rxValid,
  input  wire can_node_pkg::can_frame_s rxFrame,
  output logic                          txValid,
  output can_node_pkg::can_frame_s      txFrame,
  output logic                          pdoValid,
  output can_node_pkg::can_frame_s      pdoFrame,
  output logic [2:0]                    commState,
  output logic                          initBusy
);

  can_node_pkg::comm_state_e state;
  can_node_pkg::comm_state_e next_state;

  logic [7:0]  initCount;
  logic [6:0]  nodeAddr;
  logic        restoreAll;
  logic        restoreComm;
  logic        next_restoreAll;
  logic        next_restoreComm;

  wire         isNmt;
  wire         isCh1;
  wire         isCh2;
  wire         isPdo;

  frame_classify u_classify
  (
    .frame    (rxFrame),
    .nodeAddr (nodeAddr),
    .isNmt    (isNmt),
    .isCh1    (isCh1),
    .isCh2    (isCh2),
    .isPdo    (isPdo)
  );

  // State-change decode
  wire [7:0] nmtCmd;
  wire [7:0] nmtTarget;
  wire       nmtForMe;
  wire       nmtHit;
  wire       inInit;
  wire       inPreop;
  wire       inOper;
  wire       initDone;

  assign nmtCmd    = rxFrame.data[can_node_pkg::BYTE_CMD];
  assign nmtTarget = rxFrame.data[can_node_pkg::BYTE_IDXLO];
  assign nmtForMe  = (nmtTarget == can_node_pkg::NMT_BROADCAST)
                  || (nmtTarget == {1'b0, nodeAddr});
  assign nmtHit    = rxValid && isNmt && nmtForMe;
  assign inInit    = (state == can_node_pkg::ST_INIT);
  assign inPreop   = (state == can_node_pkg::ST_PREOP);
  assign inOper    = (state == can_node_pkg::ST_OPER);
  assign initDone  = inInit && (initCount == can_node_pkg::INIT_LAST);

  always_comb
  begin
    next_state       = state;
    next_restoreAll  = 1'b0;
    next_restoreComm = 1'b0;
    case (state)
      can_node_pkg::ST_INIT:
      begin
        if (initDone)
          next_state = can_node_pkg::ST_PREOP;
      end
      can_node_pkg::ST_PREOP:
      begin
        if (nmtHit && (nmtCmd == can_node_pkg::NMT_START))
          next_state = can_node_pkg::ST_OPER;
        else if (nmtHit && (nmtCmd == can_node_pkg::NMT_RESET_ALL))
        begin
          next_state      = can_node_pkg::ST_INIT;
          next_restoreAll = 1'b1;
        end
        else if (nmtHit && (nmtCmd == can_node_pkg::NMT_RESET_COMM))
        begin
          next_state       = can_node_pkg::ST_INIT;
          next_restoreComm = 1'b1;
        end
      end
      can_node_pkg::ST_OPER:
      begin
        if (nmtHit && (nmtCmd == can_node_pkg::NMT_PREOP))
          next_state = can_node_pkg::ST_PREOP;
        else if (nmtHit && (nmtCmd == can_node_pkg::NMT_RESET_ALL))
        begin
          next_state      = can_node_pkg::ST_INIT;
          next_restoreAll = 1'b1;
        end
        else if (nmtHit && (nmtCmd == can_node_pkg::NMT_RESET_COMM))
        begin
          next_state       = can_node_pkg::ST_INIT;
          next_restoreComm = 1'b1;
        end
      end
      default:
        next_state = can_node_pkg::ST_INIT;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      state <= can_node_pkg::ST_INIT;
    else
      state <= next_state;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      restoreAll  <= 1'b0;
      restoreComm <= 1'b0;
    end
    else
    begin
      restoreAll  <= next_restoreAll;
      restoreComm <= next_restoreComm;
    end
  end

  // Initialisation timer
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      initCount <= 8'h00;
    else if (!inInit)
      initCount <= 8'h00;
    else if (!initDone)
      initCount <= initCount + 8'h01;
  end

  // Address takes effect when initialisation ends
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      nodeAddr <= can_node_pkg::NODE_ADDR_RESET;
    else if (initDone)
      nodeAddr <= nodeAddressSetting;
  end

  // Parameter request decode
  wire        paramHit;
  wire [7:0]  cmd;
  wire [2:0]  cmdSel;
  wire [1:0]  cmdLen;
  wire [1:0]  cmdFlags;
  wire        cmdZero;
  wire        isWrite;
  wire        isRead;
  wire [15:0] index;
  wire [7:0]  subIndex;
  wire [15:0] codeNum;
  wire [3:0]  code;
  wire        badIndex;
  wire        badSub;
  wire        denied;
  wire        failed;
  wire [31:0] reqData;
  wire [31:0] lenMask;
  wire [31:0] curValue;
  wire        wide;
  wire        storeWe;

  assign paramHit = rxValid && (isCh1 || isCh2) && (inPreop || inOper);
  assign cmd      = rxFrame.data[can_node_pkg::BYTE_CMD];
  assign cmdSel   = cmd[can_node_pkg::CS_MSB:can_node_pkg::CS_LSB];
  assign cmdZero  = ~cmd[can_node_pkg::ZERO_BIT];
  assign cmdLen   = cmd[can_node_pkg::LEN_MSB:can_node_pkg::LEN_LSB];
  assign cmdFlags = cmd[can_node_pkg::ES_MSB:can_node_pkg::ES_LSB];
  assign isWrite  = cmdZero && (cmdSel == can_node_pkg::CS_WRITE)
                 && (cmdFlags == can_node_pkg::ES_WRITE);
  assign isRead   = cmdZero && (cmdSel == can_node_pkg::CS_READ)
                 && (cmdFlags == can_node_pkg::ES_READ);
  // Index sent low byte first
  assign index    = {rxFrame.data[can_node_pkg::BYTE_IDXHI],
                     rxFrame.data[can_node_pkg::BYTE_IDXLO]};
  assign subIndex = rxFrame.data[can_node_pkg::BYTE_SUB];
  assign codeNum  = can_node_pkg::INDEX_BASE - index;
  assign code     = codeNum[3:0];
  assign badIndex = (index > can_node_pkg::INDEX_BASE)
                 || (codeNum >= can_node_pkg::PARAM_COUNT_W);
  assign badSub   = (subIndex > can_node_pkg::SUBINDEX_MAX);
  assign denied   = isWrite && can_node_pkg::PARAM_RO_MASK[code];
  assign failed   = badIndex || badSub || denied;
  // Data bytes little-endian from the first data byte
  assign reqData  = {rxFrame.data[can_node_pkg::BYTE_D4],
                     rxFrame.data[can_node_pkg::BYTE_D3],
                     rxFrame.data[can_node_pkg::BYTE_D1 + 1],
                     rxFrame.data[can_node_pkg::BYTE_D1]};
  // Length code selects valid bytes
  assign lenMask  = (cmdLen == 2'h0) ? 32'hffffffff :
                    (cmdLen == 2'h1) ? 32'h00ffffff :
                    (cmdLen == 2'h2) ? 32'h0000ffff : 32'h000000ff;
  assign wide     = can_node_pkg::PARAM_WIDE_MASK[code];
  assign storeWe  = paramHit && isWrite && !failed;

  param_store u_store
  (
    .mclk        (mclk),
    .rst_n       (rst_n),
    .restoreAll  (restoreAll),
    .restoreComm (restoreComm),
    .wrEn        (storeWe),
    .wrCode      (code),
    .wrData      (reqData & lenMask),
    .rdCode      (code),
    .rdData      (curValue)
  );

  // Response assembly
  wire [10:0]              rspId;
  wire [7:0]               errCode;
  wire [31:0]              rdVal;
  wire                     answer;
  can_node_pkg::can_frame_s rsp;

  assign rspId   = isCh2 ? 11'(can_node_pkg::ID_CH2_RSP + {4'h0, nodeAddr})
                         : 11'(can_node_pkg::ID_CH1_RSP + {4'h0, nodeAddr});
  assign errCode = badIndex ? can_node_pkg::ERR_INDEX :
                   badSub   ? can_node_pkg::ERR_SUBINDEX :
                              can_node_pkg::ERR_ACCESS;
  assign rdVal   = wide ? curValue : {16'h0000, curValue[15:0]};
  assign answer  = paramHit && (isWrite || isRead);

  always_comb
  begin
    rsp.id   = rspId;
    rsp.len  = can_node_pkg::PARAM_LEN;
    rsp.data = '0;
    // Echo index and subindex
    rsp.data[can_node_pkg::BYTE_IDXLO] = rxFrame.data[can_node_pkg::BYTE_IDXLO];
    rsp.data[can_node_pkg::BYTE_IDXHI] = rxFrame.data[can_node_pkg::BYTE_IDXHI];
    rsp.data[can_node_pkg::BYTE_SUB]   = subIndex;
    if (failed)
    begin
      rsp.data[can_node_pkg::BYTE_CMD] = can_node_pkg::CMD_ERROR;
      rsp.data[can_node_pkg::BYTE_D3]  = errCode;
      rsp.data[can_node_pkg::BYTE_D4]  = can_node_pkg::ERR_CLASS;
    end
    else if (isWrite)
      rsp.data[can_node_pkg::BYTE_CMD] = can_node_pkg::CMD_WRITE_ACK;
    else
    begin
      rsp.data[can_node_pkg::BYTE_CMD] = wide ? can_node_pkg::CMD_READ_32
                                              : can_node_pkg::CMD_READ_16;
      rsp.data[can_node_pkg::BYTE_D1]     = rdVal[7:0];
      rsp.data[can_node_pkg::BYTE_D1 + 1] = rdVal[15:8];
      rsp.data[can_node_pkg::BYTE_D3]     = rdVal[23:16];
      rsp.data[can_node_pkg::BYTE_D4]     = rdVal[31:24];
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      txValid <= 1'b0;
      txFrame <= '0;
    end
    else
    begin
      txValid <= answer;
      if (answer)
        txFrame <= rsp;
    end
  end

  // Process data passes only when operational
  wire pdoHit;
  assign pdoHit = rxValid && isPdo && inOper;

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pdoValid <= 1'b0;
      pdoFrame <= '0;
    end
    else
    begin
      pdoValid <= pdoHit;
      if (pdoHit)
        pdoFrame <= rxFrame;
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      commState <= can_node_pkg::ST_INIT;
      initBusy  <= 1'b1;
    end
    else
    begin
      commState <= next_state;
      initBusy  <= (next_state == can_node_pkg::ST_INIT);
    end
  end

endmodule // can_node_ctrl
`default_nettype wire

/* File: rtl/can_node_pkg.sv */
`default_nettype none
package can_node_pkg;

  // Frame as seen by the node
  typedef struct packed {
    logic [10:0]     id;
    logic [3:0]      len;
    logic [7:0][7:0] data;
  } can_frame_s;

  typedef enum logic [2:0] {
    ST_INIT   = 3'b001,
    ST_PREOP  = 3'b010,
    ST_OPER   = 3'b100
  } comm_state_e;

  // Identifier bases
  localparam logic [10:0] ID_NMT      = 11'h000;
  localparam logic [10:0] ID_CH1_REQ  = 11'h600;
  localparam logic [10:0] ID_CH2_REQ  = 11'h640;
  localparam logic [10:0] ID_CH1_RSP  = 11'h580;
  localparam logic [10:0] ID_CH2_RSP  = 11'h5c0;
  localparam logic [10:0] ID_PDO1_IN  = 11'h200;
  localparam logic [10:0] ID_PDO2_IN  = 11'h280;
  localparam logic [10:0] ID_PDO3_IN  = 11'h300;

  localparam logic [3:0] NMT_LEN   = 4'h2;
  localparam logic [3:0] PARAM_LEN = 4'h8;

  // State-change commands
  localparam logic [7:0] NMT_START      = 8'h01;
  localparam logic [7:0] NMT_PREOP      = 8'h80;
  localparam logic [7:0] NMT_RESET_ALL  = 8'h81;
  localparam logic [7:0] NMT_RESET_COMM = 8'h82;
  localparam logic [7:0] NMT_BROADCAST  = 8'h00;

  // Payload byte positions
  localparam int BYTE_CMD   = 0;
  localparam int BYTE_IDXLO = 1;
  localparam int BYTE_IDXHI = 2;
  localparam int BYTE_SUB   = 3;
  localparam int BYTE_D1    = 4;
  localparam int BYTE_D3    = 6;
  localparam int BYTE_D4    = 7;

  // Command byte fields
  localparam int CS_MSB   = 7;
  localparam int CS_LSB   = 5;
  localparam int ZERO_BIT = 4;
  localparam int LEN_MSB  = 3;
  localparam int LEN_LSB  = 2;
  localparam int ES_MSB   = 1;
  localparam int ES_LSB   = 0;
  localparam logic [2:0] CS_WRITE = 3'h1;
  localparam logic [2:0] CS_READ  = 3'h2;
  localparam logic [1:0] ES_WRITE = 2'h3;
  localparam logic [1:0] ES_READ  = 2'h0;

  localparam logic [7:0] CMD_WRITE_ACK = 8'h60;
  localparam logic [7:0] CMD_READ_32   = 8'h43;
  localparam logic [7:0] CMD_READ_16   = 8'h4b;
  localparam logic [7:0] CMD_ERROR     = 8'h80;

  localparam logic [7:0] ERR_CLASS    = 8'h06;
  localparam logic [7:0] ERR_INDEX    = 8'h06;
  localparam logic [7:0] ERR_SUBINDEX = 8'h05;
  localparam logic [7:0] ERR_ACCESS   = 8'h03;

  // Parameter table
  localparam logic [15:0] INDEX_BASE  = 16'h5fff;
  localparam int          PARAM_COUNT = 16;
  localparam int          CODE_W      = 4;
  localparam logic [15:0] PARAM_COUNT_W = 16'h0010;
  localparam logic [7:0]  SUBINDEX_MAX  = 8'h00;
  localparam logic [15:0] PARAM_RO_MASK   = 16'h0002;
  localparam logic [15:0] PARAM_COMM_MASK = 16'h000c;
  localparam logic [15:0] PARAM_WIDE_MASK = 16'hfff0;
  localparam int          FIXED_SCALE     = 10000;

  // Initialisation time
  localparam int INIT_TIME_NS  = 1000;
  localparam int CLK_PERIOD_NS = 10;
  localparam int INIT_CYCLES   = (INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] INIT_LAST = 8'(INIT_CYCLES - 1);
  localparam logic [6:0] NODE_ADDR_RESET = 7'h00;

endpackage
`default_nettype wire

/* File: rtl/frame_classify.sv */
`timescale 1ns/1ps
`default_nettype none
module frame_classify
(
  input  wire can_node_pkg::can_frame_s frame,
  input  wire logic [6:0]               nodeAddr,
  output logic                          isNmt,
  output logic                          isCh1,
  output logic                          isCh2,
  output logic                          isPdo
);

  wire [10:0] addr11;

  assign addr11 = {4'h0, nodeAddr};
  // Fixed identifier for state changes
  assign isNmt = (frame.id == can_node_pkg::ID_NMT)
               && (frame.len == can_node_pkg::NMT_LEN);
  // Channel identifiers follow the node address
  assign isCh1 = (frame.id == 11'(can_node_pkg::ID_CH1_REQ + addr11))
               && (frame.len == can_node_pkg::PARAM_LEN);
  assign isCh2 = (frame.id == 11'(can_node_pkg::ID_CH2_REQ + addr11))
               && (frame.len == can_node_pkg::PARAM_LEN);
  assign isPdo = (frame.id == 11'(can_node_pkg::ID_PDO1_IN + addr11))
              || (frame.id == 11'(can_node_pkg::ID_PDO2_IN + addr11))
              || (frame.id == 11'(can_node_pkg::ID_PDO3_IN + addr11));

endmodule // frame_classify
`default_nettype wire

/* File: rtl/param_store.sv */
`timescale 1ns/1ps
`default_nettype none
module param_store
(
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        restoreAll,
  input  wire logic        restoreComm,
  input  wire logic        wrEn,
  input  wire logic [3:0]  wrCode,
  input  wire logic [31:0] wrData,
  input  wire logic [3:0]  rdCode,
  output logic      [31:0] rdData
);

  logic [31:0] entries [can_node_pkg::PARAM_COUNT];

  assign rdData = entries[rdCode];

  genvar i;
  generate
    for (i = 0; i < can_node_pkg::PARAM_COUNT; i++)
    begin : g_entry
      // Defaults in fixed-point, scaled by ten thousand
      localparam logic [31:0] DEFVAL = 32'(i * can_node_pkg::FIXED_SCALE);
      wire restoreHit;
      assign restoreHit = restoreAll
                        || (restoreComm && can_node_pkg::PARAM_COMM_MASK[i]);
      always_ff @(posedge mclk or negedge rst_n)
      begin
        if (!rst_n)
          entries[i] <= DEFVAL;
        else if (restoreHit)
          entries[i] <= DEFVAL;
        else if (wrEn && (wrCode == 4'(i)))
          entries[i] <= wrData;
      end
    end
  endgenerate

endmodule // param_store
`default_nettype wire

/* File: dv/can_node_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module can_node_chk
(
  input wire logic                     mclk,
  input wire logic                     rst_n,
  input wire logic [6:0]               nodeAddressSetting,
  input wire logic                     rxValid,
  input wire can_node_pkg::can_frame_s rxFrame,
  input wire logic                     txValid,
  input wire can_node_pkg::can_frame_s txFrame,
  input wire logic                     pdoValid,
  input wire logic [2:0]               commState,
  input wire logic                     initBusy
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  // Cycles spent in initialisation
  logic [7:0] initCnt;
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
      initCnt <= 8'h00;
    else if (commState != 3'b001)
      initCnt <= 8'h00;
    else if (initCnt != 8'hff)
      initCnt <= initCnt + 8'h01;

  sequence s_nmt(logic [7:0] c);
    rxValid && rxFrame.id == 11'h000 && rxFrame.len == 4'h2 && rxFrame.data[0] == c
      && (rxFrame.data[1] == 8'h00 || rxFrame.data[1] == {1'b0, nodeAddressSetting});
  endsequence

  property p_start;
    s_nmt(8'h01) ##0 commState == 3'b010 |=> commState == 3'b100;
  endproperty
  property p_stop;
    s_nmt(8'h80) ##0 commState == 3'b100 |=> commState == 3'b010;
  endproperty
  property p_reinit;
    rxValid && rxFrame.id == 11'h000 && rxFrame.len == 4'h2
      && (rxFrame.data[1] == 8'h00 || rxFrame.data[1] == {1'b0, nodeAddressSetting})
      && rxFrame.data[0] inside {8'h81, 8'h82} && commState != 3'b001
      |=> commState == 3'b001 && initBusy;
  endproperty
  property p_other;
    rxValid && rxFrame.id == 11'h000 && rxFrame.data[1] != 8'h00 && commState != 3'b001
      && rxFrame.data[1] != {1'b0, nodeAddressSetting} |=> $stable(commState);
  endproperty
  property p_pdo;
    pdoValid |-> $past(commState) == 3'b100;
  endproperty
  property p_ignore;
    rxValid && commState == 3'b001 |=> !txValid;
  endproperty
  property p_rspId;
    txValid |-> $past(rxValid) && txFrame.id == $past(rxFrame.id) - 11'h080;
  endproperty
  property p_echo;
    txValid |-> txFrame.data[3:1] == $past(rxFrame.data[3:1]);
  endproperty
  property p_err;
    txValid && txFrame.data[0] == 8'h80 |-> txFrame.data[7] == 8'h06
      && txFrame.data[6] inside {8'h06, 8'h05, 8'h03};
  endproperty
  property p_init;
    $past(commState) == 3'b001 && commState == 3'b010
      |-> initCnt == 8'(can_node_pkg::INIT_CYCLES);
  endproperty

  a_start: assert property (p_start) else $error("start not taken");
  a_stop: assert property (p_stop) else $error("stop not taken");
  a_reinit: assert property (p_reinit) else $error("reset not taken");
  a_other: assert property (p_other) else $error("foreign address acted on");
  a_pdo: assert property (p_pdo) else $error("process data outside operation");
  a_ignore: assert property (p_ignore) else $error("answer during init");
  a_rspId: assert property (p_rspId) else $error("bad answer identifier");
  a_echo: assert property (p_echo) else $error("index not echoed");
  a_err: assert property (p_err) else $error("bad error frame");
  a_init: assert property (p_init) else $error("init length wrong");
endmodule // can_node_chk

bind can_node_ctrl can_node_chk u_can_node_chk (.mclk(mclk), .rst_n(rst_n),
  .nodeAddressSetting(nodeAddressSetting), .rxValid(rxValid), .rxFrame(rxFrame),
  .txValid(txValid), .txFrame(txFrame), .pdoValid(pdoValid), .commState(commState),
  .initBusy(initBusy));
`default_nettype wire

/* File: dv/can_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module can_host_model
(
  input  wire logic                     mclk,
  input  wire logic [6:0]               nodeAddr,
  input  wire logic                     txValid,
  input  wire can_node_pkg::can_frame_s txFrame,
  output logic                          rxValid,
  output can_node_pkg::can_frame_s      rxFrame
);
  initial
  begin
    rxValid = 1'b0;
    rxFrame = '0;
  end

  // One frame for one cycle, then a scrambled idle bus
  task automatic send(input can_node_pkg::can_frame_s f, output logic got,
                      output can_node_pkg::can_frame_s rsp);
    @(posedge mclk);
    #1;
    rxValid = 1'b1;
    rxFrame = f;
    @(posedge mclk);
    #1;
    rxValid = 1'b0;
    rxFrame = ~f;
    got = txValid;
    rsp = txFrame;
  endtask

  task automatic param(input logic ch, input logic [7:0] cmd, input logic [15:0] idx,
                       input logic [7:0] sub, input logic [31:0] val, output logic got,
                       output can_node_pkg::can_frame_s rsp);
    can_node_pkg::can_frame_s f;
    f.id = (ch ? 11'h640 : 11'h600) + {4'h0, nodeAddr};
    f.len = 4'h8;
    f.data = {val, sub, idx, cmd};
    send(f, got, rsp);
  endtask

  task automatic nmt(input logic [7:0] cmd, input logic [7:0] addr);
    can_node_pkg::can_frame_s f;
    can_node_pkg::can_frame_s r;
    logic g;
    f = '0;
    f.len = 4'h2;
    f.data[0] = cmd;
    f.data[1] = addr;
    send(f, g, r);
  endtask
endmodule // can_host_model
`default_nettype wire

/* File: dv/test_can_node_state_and_param_channel.sv */
`timescale 1ns/1ps
`default_nettype none
module test_can_node_state_and_param_channel;
  logic                     mclk = 1'b0;
  logic                     rst_n = 1'b0;
  logic [6:0]               nodeAddr = 7'h05;
  logic                     rxValid, txValid, pdoValid, initBusy, got;
  logic [2:0]               commState;
  can_node_pkg::can_frame_s rxFrame, txFrame, pdoFrame, rsp, raw;
  logic [31:0]              mem [16];
  logic [7:0]               cmds [6] = '{8'h23, 8'h27, 8'h2b, 8'h2f, 8'h40, 8'h40};
  int                       err_total = 0;
  int                       num_checks = 0;

  always #5 mclk = ~mclk;

  can_node_ctrl u_can_node_ctrl (.mclk(mclk), .rst_n(rst_n), .nodeAddressSetting(nodeAddr),
    .rxValid(rxValid), .rxFrame(rxFrame), .txValid(txValid), .txFrame(txFrame),
    .pdoValid(pdoValid), .pdoFrame(pdoFrame), .commState(commState), .initBusy(initBusy));
  can_host_model u_host (.mclk(mclk), .nodeAddr(nodeAddr), .txValid(txValid),
    .txFrame(txFrame), .rxValid(rxValid), .rxFrame(rxFrame));

  task automatic close_out();
    $display("checks=%0d errors=%0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic check(input logic [79:0] act, input logic [79:0] exp);
    num_checks++;
    if (act !== exp)
    begin
      err_total++;
      $display("[FAIL] t=%0t act=%h exp=%h", $time, act, exp);
    end
  endtask

  // Expected answer, updating the table copy on a good write
  function automatic logic [74:0] expRsp(input logic ch, input logic [7:0] cmd, input int code,
                                         input logic [7:0] sub, input logic [31:0] val);
    logic [7:0]  c = 8'h80;
    logic [31:0] d = 32'h06060000;
    if (code > 15)
      d = 32'h06060000;
    else if (sub != 8'h00)
      d = 32'h06050000;
    else if (cmd == 8'h40)
    begin
      c = (code < 4) ? 8'h4b : 8'h43;
      d = (code < 4) ? {16'h0000, mem[code][15:0]} : mem[code];
    end
    else if (code == 1)
      d = 32'h06030000;
    else
    begin
      c = 8'h60;
      d = 32'h0;
      mem[code] = val & (32'hffffffff >> (8 * cmd[3:2]));
    end
    return {(ch ? 11'h5c0 : 11'h580) + {4'h0, nodeAddr}, d, sub, 16'h5fff - 16'(code), c};
  endfunction

  task automatic op(input logic ch, input logic [7:0] cmd, input int code,
                    input logic [7:0] sub, input logic [31:0] val);
    logic [74:0] e;
    e = expRsp(ch, cmd, code, sub, val);
    u_host.param(ch, cmd, 16'h5fff - 16'(code), sub, val, got, rsp);
    check({got, rsp.id, rsp.len, rsp.data}, {1'b1, e[74:64], 4'h8, e[63:0]});
  endtask

  task automatic waitPreop();
    for (int i = 0; i < 300 && commState !== 3'b010; i++)
    begin
      @(posedge mclk);
      #1;
    end
    check(commState, 3'b010);
    check(initBusy, 1'b0);
  endtask

  task automatic sendRaw(input logic [10:0] id, input logic [3:0] len, input logic [63:0] d);
    raw.id = id;
    raw.len = len;
    raw.data = d;
    u_host.send(raw, got, rsp);
  endtask

  initial
  begin
    void'($urandom(32'h0c2f));
    nodeAddr = 7'($urandom_range(127, 2));
    for (int i = 0; i < 16; i++)
      mem[i] = i * 10000;
    repeat (20) @(posedge mclk);
    #1 rst_n = 1'b1;
    check({commState, initBusy}, 4'b0011);
    u_host.param(1'b0, 8'h40, 16'h5ff3, 8'h00, 32'h0, got, rsp);
    check(got, 1'b0);
    waitPreop();
    sendRaw(11'h200 + nodeAddr, 4'h8, {$urandom, $urandom});
    check(pdoValid, 1'b0);
    op(1'b0, 8'h23, 12, 8'h00, 32'h00030d40);
    op(1'b0, 8'h40, 12, 8'h00, 32'h0);
    for (int i = 0; i < 4; i++)
    begin
      op(1'b1, cmds[i], 8, 8'h00, 32'hffffffff);
      op(1'b1, 8'h40, 8, 8'h00, 32'h0);
    end
    op(1'b0, 8'h23, 1, 8'h00, 32'h5);
    op(1'b1, 8'h40, 20, 8'h00, 32'h0);
    op(1'b0, 8'h40, 5, 8'h01, 32'h0);
    op(1'b0, 8'h23, 20, 8'h03, 32'h0);
    sendRaw(11'h600 + nodeAddr, 4'h7, 64'h0000_0000_005f_f340);
    check(got, 1'b0);
    sendRaw(11'h600 + nodeAddr, 4'h8, 64'h0000_0000_005f_f320);
    check(got, 1'b0);
    u_host.nmt(8'h01, {1'b0, nodeAddr ^ 7'h01});
    check(commState, 3'b010);
    u_host.nmt(8'h01, 8'h00);
    check(commState, 3'b100);
    sendRaw(11'h280 + nodeAddr, 4'h8, {$urandom, $urandom});
    check({pdoValid, pdoFrame}, {1'b1, raw});
    sendRaw(11'h300 + nodeAddr, 4'h8, {$urandom, $urandom});
    check({pdoValid, pdoFrame}, {1'b1, raw});
    for (int i = 0; i < 60; i++)
      op(1'($urandom), cmds[$urandom_range(5, 0)], $urandom_range(19, 0),
         8'($urandom_range(7, 0) == 0), $urandom);
    u_host.nmt(8'h80, {1'b0, nodeAddr});
    check(commState, 3'b010);
    op(1'b0, 8'h23, 2, 8'h00, 32'h11);
    op(1'b0, 8'h23, 5, 8'h00, 32'h55);
    u_host.nmt(8'h82, {1'b0, nodeAddr});
    check(commState, 3'b001);
    mem[2] = 20000;
    mem[3] = 30000;
    waitPreop();
    op(1'b0, 8'h40, 2, 8'h00, 32'h0);
    op(1'b0, 8'h40, 5, 8'h00, 32'h0);
    u_host.nmt(8'h81, 8'h00);
    check(commState, 3'b001);
    for (int i = 0; i < 16; i++)
      mem[i] = i * 10000;
    waitPreop();
    for (int i = 0; i < 16; i++)
      op(1'b1, 8'h40, i, 8'h00, 32'h0);
    close_out();
  end

  initial
  begin
    #100000;
    err_total++;
    close_out();
  end
endmodule // test_can_node_state_and_param_channel
`default_nettype wire
